/* test/ctrl_model.sv */
// Machine controller model driving the six select lines.
// Assumes lines change just after a clock edge.
`timescale 1ns/10ps
module ctrl_model (
  input wire logic sys_clk, // System clock
  input wire logic slow, // Ripple one line per cycle
  input wire logic [5:0] code, // Wanted set number
  output logic [5:0] sel_lines // Line 0 first
);
  logic [2:0] k_r = 3'h0;
  initial sel_lines = 6'h3f;
  always @(posedge sys_clk) begin
    k_r <= k_r + 3'h1;
    if (!slow) sel_lines <= ~code;
    else if (k_r < 3'h6) sel_lines[k_r] <= ~code[k_r];
  end
endmodule

/* test/field_set_select_chk.sv */
// Port checks for the field set selection block.
// Assumes one clock domain.
`timescale 1ns/10ps
module field_set_select_chk (
  input wire logic sys_clk, rstn, // Clock, reset
  input wire logic [2:0] op_mode, field_configured, field_object, field_led, // Mode, fields
  input wire logic [5:0] active_set, // Active set
  input wire logic set_switch_pulse, set_reject_pulse, scan_boundary, sensor_health_out, status_on, // Events
  input wire logic [1:0] status_color, // Colour
  input wire logic field_a_detect_out, field_b_detect_out, field_c_detect_out, // Levels
  input wire logic field_a_detect_oe, field_b_detect_oe, field_c_detect_oe // Enables
);
  logic [2:0] lv, oe;
  logic [1:0] up_r;
  assign lv = {field_c_detect_out, field_b_detect_out, field_a_detect_out};
  assign oe = {field_c_detect_oe, field_b_detect_oe, field_a_detect_oe};
  // Edges since release, so old reset-time history is never judged
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) up_r <= 2'h0;
    else up_r <= {up_r[0], 1'b1};
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_event_on_bnd: assert property ((set_switch_pulse || set_reject_pulse) |-> scan_boundary)
    else $error("set event off boundary");
  a_active_held: assert property (up_r[0] && active_set != $past(active_set) |-> set_switch_pulse)
    else $error("active set moved");
  a_reject_keeps: assert property (set_reject_pulse |-> $stable(active_set) && !set_switch_pulse)
    else $error("reject changed set");
  a_field_gate: assert property (up_r[0] |-> lv == $past(field_object & field_configured & {3{op_mode == 3'h0}}))
    else $error("field output wrong");
  a_open_drain: assert property (lv == oe)
    else $error("enable differs");
  a_health_mode: assert property (up_r[0] |-> sensor_health_out == ($past(op_mode) == 3'h0))
    else $error("health wrong");
  // Indicators are registered once from the mode code, so they trail it by one edge
  a_busy_leds: assert property (up_r[1] && $past(op_mode) == 3'h1 |-> status_color == 2'h1 && status_on && field_led == 3'h7)
    else $error("busy indicators wrong");
  a_normal_leds: assert property (up_r[1] && $past(op_mode) == 3'h0 |-> status_color == 2'h2 && status_on && field_led == $past(lv))
    else $error("normal indicators wrong");
  a_dark_off: assert property (up_r[1] && $past(op_mode) == 3'h3 |-> !status_on && field_led == 3'h0)
    else $error("shutdown not dark");
  a_align_steady: assert property (up_r[1] && $past(op_mode) == 3'h4 |-> status_color == 2'h3 && status_on)
    else $error("alignment wrong");
  a_fatal_flash: assert property (up_r[1] && $past(op_mode) == 3'h2 |-> status_color == 2'h1 && field_led == {3{status_on}})
    else $error("fatal indicators wrong");
  cover property (set_switch_pulse);
  cover property (set_reject_pulse);
  cover property (op_mode == 3'h2 ##1 $fell(status_on));
endmodule
bind field_set_select field_set_select_chk chk (.*);

/* test/field_set_select_tb.sv */
// Bench for field set selection: set switching, then a mode sweep.
// Assumes short scan and flash counts set below.
`timescale 1ns/10ps
module field_set_select_tb;
  import fieldsel_pkg::*;
  localparam int SL = 20;
  logic sys_clk = 1'b0, rstn = 1'b0, slow = 1'b0, scan_sync = 1'b0, scan_sync_en = 1'b0;
  logic [63:0] set_configured = 64'h0;
  logic [2:0] field_configured = 3'h0, field_object = 3'h0, op_mode = 3'h0, fld, field_led;
  logic [5:0] code = 6'h0, sel, active_set, requested_set, exp_act = 6'h0;
  logic [1:0] status_color;
  logic set_switch_pulse, set_reject_pulse, scan_boundary, sensor_health_out, status_on;
  logic field_a_detect_out, field_a_detect_oe, field_b_detect_out, field_b_detect_oe;
  logic field_c_detect_out, field_c_detect_oe;
  logic [7:0] ons;
  logic [31:0] r = 32'h9f82;
  int n_errors = 0, n_compared = 0, cnt;
  field_set_select #(.SCAN_LEN(SL), .FLASH_HALF(4)) uut (.select_line_0(sel[0]), .select_line_1(sel[1]),
    .select_line_2(sel[2]), .select_line_3(sel[3]), .select_line_4(sel[4]), .select_line_5(sel[5]), .*);
  ctrl_model ctl (.sys_clk(sys_clk), .slow(slow), .code(code), .sel_lines(sel));
  initial forever #5 sys_clk = ~sys_clk;
  function automatic logic [1:0] ecol(input int m);
    return m == 0 ? LED_GREEN : m < 3 ? LED_RED : (m == 4 || m == 5) ? LED_YELLOW : LED_OFF;
  endfunction
  task automatic nx();
    r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
  endtask
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_bnd(output int n);
    n = 0;
    do begin
      step();
      n++;
    end while (scan_boundary !== 1'b1 && n < 100);
  endtask
  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #30000;
    n_errors++;
    end_sim();
  end
  initial begin
    nx();
    set_configured[31:0] = r;
    nx();
    set_configured[63:32] = r;
    set_configured[63] = 1'b1;
    set_configured[5] = 1'b0;
    repeat (2) step();
    rstn = 1'b1;
    for (int i = 0; i < 16; i++) begin
      nx();
      wait_bnd(cnt);
      code = (i == 0) ? 6'h3f : (i == 1) ? 6'h05 : (i == 2) ? 6'h00 : r[5:0];
      slow = i[0];
      step();
      wait_bnd(cnt);
      chk(8'(cnt), 8'(SL - 1));
      exp_act = set_configured[code] ? code : exp_act;
      chk(8'(active_set), 8'(exp_act));
      chk(8'(requested_set), 8'(code));
    end
    for (int m = 0; m < 8; m++) begin
      nx();
      op_mode = 3'(m);
      field_object = r[2:0];
      field_configured = r[5:3];
      fld = r[2:0] & r[5:3];
      scan_sync_en = 1'b1;
      scan_sync = r[6];
      repeat (3) step();
      for (int k = 0; k < 8; k++) begin
        ons[k] = status_on;
        if (m == 2) chk(8'(field_led), {5'h0, {3{status_on}}});
        step();
      end
      chk(8'(status_color), 8'(ecol(m)));
      chk(8'(sensor_health_out), 8'(m == 0));
      chk({5'h0, field_c_detect_out, field_b_detect_out, field_a_detect_out}, m == 0 ? 8'(fld) : 8'h0);
      chk({5'h0, field_c_detect_oe, field_b_detect_oe, field_a_detect_oe}, m == 0 ? 8'(fld) : 8'h0);
      if (m == 2 || m == 5) chk(8'(ons != 8'h0 && ons != 8'hff), 8'h1);
      else chk(ons, (m == 0 || m == 1 || m == 4) ? 8'hff : 8'h0);
      if (m != 2) chk(8'(field_led), m == 0 ? 8'(fld) : m == 1 ? 8'h7 : 8'h0);
    end
    end_sim();
  end
endmodule

/* verilog/field_set_select.sv */
// Field set selection and switching outputs of the field monitor.
// Assumes select lines come from isolated pins (asynchronous) and the
// ranging/evaluation engine supplies per-field hits and configured flags.
//
// Behaviour
// - Sixty-four field sets, chosen by six select input lines.
// - Set number is bitwise inverse of lines; line 0 is the LSB.
// - Selecting an unconfigured set is ignored; previous set stays active.
// - New set applied only at the next scan boundary, within about 50 ms of change.
// - Field output asserted in normal operation while object detected inside its field.
// - Field output never asserted when its field is unconfigured.
// - Inactive output floats; active output switched to output common.
// - Health output high during normal operation, low otherwise.
// - Busy states: status steady red, all field indicators steady on.
// - Normal: status green, field indicators mirror field outputs.
// - Fatal flashes red and fields; shutdown dark; alignment, identify yellow.
`timescale 1ns/10ps
`include "fieldsel_defines.svh"
module field_set_select
  import fieldsel_pkg::*;
#(
  parameter int SCAN_LEN = `SCAN_CYCLES,
  parameter int FLASH_HALF = `FLASH_HALF_CYCLES
) (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic select_line_0, // Select pin, high = bit 0 clear
  input wire logic select_line_1, // Select pin
  input wire logic select_line_2, // Select pin
  input wire logic select_line_3, // Select pin
  input wire logic select_line_4, // Select pin
  input wire logic select_line_5, // Select pin, bit 5
  input wire logic [`NUM_SETS-1:0] set_configured, // Per-set configured flag
  input wire logic [`NUM_FIELDS-1:0] field_configured, // Fields configured in active set
  input wire logic [`NUM_FIELDS-1:0] field_object, // Object seen per field this scan
  input wire logic [2:0] op_mode, // Operating mode code, op_mode_e
  input wire logic scan_sync, // Scan boundary pulse from ranging engine
  input wire logic scan_sync_en, // Use scan_sync instead of internal timer
  output logic [`SEL_W-1:0] active_set, // Active field set number
  output logic [`SEL_W-1:0] requested_set, // Last sampled requested set
  output logic set_switch_pulse, // One cycle on field set change
  output logic set_reject_pulse, // One cycle when request refused
  output logic scan_boundary, // One cycle at every scan boundary
  output logic field_a_detect_out, // Field A output level when driven
  output logic field_a_detect_oe, // Field A tied to output common when high
  output logic field_b_detect_out, // Field B output level
  output logic field_b_detect_oe, // Field B enable
  output logic field_c_detect_out, // Field C output level
  output logic field_c_detect_oe, // Field C enable
  output logic sensor_health_out, // High while operating normally
  output logic [1:0] status_color, // Status indicator colour, led_color_e
  output logic status_on, // Status indicator lit
  output logic [`NUM_FIELDS-1:0] field_led // Field indicators lit
);
  logic [`SEL_W-1:0] sel_meta_r;
  logic [`SEL_W-1:0] sel_sync_r;
  logic [31:0] scan_cnt_r;
  logic boundary;
  logic [`SEL_W-1:0] set_nxt;
  logic [`SEL_W-1:0] active_set_r;
  logic [`SEL_W-1:0] requested_set_r;
  logic switch_r;
  logic reject_r;
  logic boundary_r;
  logic [`NUM_FIELDS-1:0] field_on_r;
  logic health_r;
  op_mode_e mode;
  logic [`SEL_W-1:0] raw_lines;

  assign raw_lines = {select_line_5, select_line_4, select_line_3,
                      select_line_2, select_line_1, select_line_0};
  assign mode = op_mode_e'(op_mode);

  // Two-stage synchroniser; meta stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sel_meta_r <= 6'h3f;
      sel_sync_r <= 6'h3f;
    end else begin
      sel_meta_r <= raw_lines;
      sel_sync_r <= sel_meta_r;
    end
  end

  // Internal scan timer; external sync preferred when the engine provides it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scan_cnt_r <= 32'h0;
    end else if (boundary) begin
      scan_cnt_r <= 32'h0;
    end else begin
      scan_cnt_r <= scan_cnt_r + 32'h1;
    end
  end

  assign boundary = scan_sync_en ? scan_sync : (scan_cnt_r >= SCAN_LEN - 1);

  // Inverted code, line 0 as LSB
  assign set_nxt = ~sel_sync_r;

  // Selection applied only at a scan boundary
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      active_set_r <= 6'h0;
      requested_set_r <= 6'h0;
      switch_r <= 1'b0;
      reject_r <= 1'b0;
    end else begin
      switch_r <= 1'b0;
      reject_r <= 1'b0;
      if (boundary) begin
        requested_set_r <= set_nxt;
        if (set_nxt != active_set_r) begin
          if (set_configured[set_nxt]) begin
            active_set_r <= set_nxt;
            switch_r <= 1'b1;
          end else begin
            reject_r <= 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      boundary_r <= 1'b0;
    end else begin
      boundary_r <= boundary;
    end
  end

  // Field outputs; held off outside normal operation and when unconfigured
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_FIELDS; gi = gi + 1) begin : g_field
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          field_on_r[gi] <= 1'b0;
        end else begin
          field_on_r[gi] <= (mode == MODE_NORMAL) && field_configured[gi] && field_object[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      health_r <= 1'b0;
    end else begin
      health_r <= (mode == MODE_NORMAL);
    end
  end

  // Open when inactive, driven to common when active
  assign field_a_detect_out = field_on_r[0];
  assign field_a_detect_oe = field_on_r[0];
  assign field_b_detect_out = field_on_r[1];
  assign field_b_detect_oe = field_on_r[1];
  assign field_c_detect_out = field_on_r[2];
  assign field_c_detect_oe = field_on_r[2];
  assign sensor_health_out = health_r;
  assign active_set = active_set_r;
  assign requested_set = requested_set_r;
  assign set_switch_pulse = switch_r;
  assign set_reject_pulse = reject_r;
  assign scan_boundary = boundary_r;

  led_bus_if leds ();
  assign leds.mode = mode;
  assign leds.field_hit = field_on_r;

  led_driver #(
    .FLASH_HALF(FLASH_HALF)
  ) u_led (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .leds(leds)
  );

  assign status_color = leds.status_color;
  assign status_on = leds.status_on;
  assign field_led = leds.field_led;
endmodule

/* verilog/fieldsel_defines.svh */
// Timing counts and codes for the field set selection block.
// Assumes a 100 MHz system clock.
`ifndef FIELDSEL_DEFINES_SVH
`define FIELDSEL_DEFINES_SVH
`define CLK_PERIOD_NS 10
`define SCAN_PERIOD_MS 50
`define SCAN_CYCLES ((`SCAN_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)
`define FLASH_HALF_MS 250
`define FLASH_HALF_CYCLES ((`FLASH_HALF_MS * 1000000) / `CLK_PERIOD_NS)
`define NUM_SETS 64
`define SEL_W 6
`define NUM_FIELDS 3
`endif

/* verilog/fieldsel_pkg.sv */
// Types for the field set selection block.
// Assumes fieldsel_defines.svh is included by users that need counts.
package fieldsel_pkg;
  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_BUSY,
    MODE_FATAL,
    MODE_SHUTDOWN,
    MODE_ALIGN,
    MODE_IDENTIFY
  } op_mode_e;
  typedef enum logic [1:0] {
    LED_OFF,
    LED_RED,
    LED_GREEN,
    LED_YELLOW
  } led_color_e;
endpackage

/* verilog/led_bus_if.sv */
// Carries indicator requests from the top to the indicator driver.
// Assumes one clock domain.
`timescale 1ns/10ps
interface led_bus_if;
  import fieldsel_pkg::*;
  op_mode_e mode;
  logic [2:0] field_hit;
  led_color_e status_color;
  logic status_on;
  logic [2:0] field_led;
  modport ctrl (output mode, output field_hit, input status_color, input status_on, input field_led);
  modport drv (input mode, input field_hit, output status_color, output status_on, output field_led);
endinterface

/* verilog/led_driver.sv */
// Indicator driver: maps operating mode and field hits to four indicators.
// Assumes a free running clock; flash rate from an internal divider.
`timescale 1ns/10ps
`include "fieldsel_defines.svh"
module led_driver
  import fieldsel_pkg::*;
#(
  parameter int FLASH_HALF = `FLASH_HALF_CYCLES
) (
  input wire logic sys_clk, // System clock
  input wire logic rstn, // Async reset, active low
  led_bus_if.drv leds // Mode in, indicator states out
);
  logic [31:0] flash_cnt_r;
  logic blink_r;
  led_color_e status_color_r;
  logic status_on_r;
  logic [2:0] field_led_r;

  // Flash phase divider
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flash_cnt_r <= 32'h0;
      blink_r <= 1'b0;
    end else if (flash_cnt_r >= FLASH_HALF - 1) begin
      flash_cnt_r <= 32'h0;
      blink_r <= ~blink_r;
    end else begin
      flash_cnt_r <= flash_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      status_color_r <= LED_RED;
      status_on_r <= 1'b1;
      field_led_r <= 3'h7;
    end else begin
      case (leds.mode)
        MODE_NORMAL: begin
          status_color_r <= LED_GREEN;
          status_on_r <= 1'b1;
          field_led_r <= leds.field_hit;
        end
        MODE_BUSY: begin
          status_color_r <= LED_RED;
          status_on_r <= 1'b1;
          field_led_r <= 3'h7;
        end
        MODE_FATAL: begin
          status_color_r <= LED_RED;
          status_on_r <= blink_r;
          field_led_r <= {3{blink_r}};
        end
        MODE_ALIGN: begin
          status_color_r <= LED_YELLOW;
          status_on_r <= 1'b1;
          field_led_r <= 3'h0;
        end
        MODE_IDENTIFY: begin
          status_color_r <= LED_YELLOW;
          status_on_r <= blink_r;
          field_led_r <= 3'h0;
        end
        default: begin
          status_color_r <= LED_OFF;
          status_on_r <= 1'b0;
          field_led_r <= 3'h0;
        end
      endcase
    end
  end

  assign leds.status_color = status_color_r;
  assign leds.status_on = status_on_r;
  assign leds.field_led = field_led_r;
endmodule
